// ===== rtl/brake_cfg_pkg.sv
// Package with offsets, field layouts, reset values and timing constants of the config bank.
package brake_cfg_pkg;

  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 32;
  localparam logic [7:0] REV_DRIVE_OFS   = 8'h82;
  localparam logic [7:0] STARTUP_ONE_OFS = 8'h84;
  localparam logic [31:0] REV_DRIVE_RST  = 32'h00000000;
  localparam logic [31:0] STARTUP_ONE_RST = 32'h00000000;

  // Reverse drive configuration word fields.
  localparam int PARITY_BIT   = 31;
  localparam int LIN_ACC_LSB  = 27;
  localparam int QUAD_ACC_LSB = 23;
  localparam int BRAKE_I_LSB  = 20;
  localparam int KP_LSB       = 10;
  localparam int KI_LSB       = 0;
  localparam int CODE_W       = 4;
  localparam int BRAKE_I_W    = 3;
  localparam int GAIN_W       = 10;

  // Gain scaling as fractional bits of the fixed point result.
  localparam int KP_FRAC_BITS = 7;
  localparam int KI_FRAC_BITS = 9;

  // Startup word fields used by this block.
  localparam int REV_EN_BIT   = 0;
  localparam int BRAKE_EN_BIT = 1;

  // Decoded widths: acceleration in 0.01 Hz/s units, current in mA.
  localparam int ACC_W = 20;
  localparam int CUR_W = 13;
  localparam logic [CUR_W-1:0] BRAKE_I_ZERO_MA = 13'h01F4;
  localparam logic [CUR_W-1:0] BRAKE_I_STEP_MA = 13'h03E8;

  // Ramp update period.
  localparam int RAMP_TICK_US     = 1000;
  localparam int CLK_MHZ          = 50;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * CLK_MHZ;
  localparam int FREQ_W           = 32;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_RUN  = 2'b01
  } ramp_state_t;

endpackage

// ===== rtl/brake_cfg_if.sv
// Interface carrying field codes to the decoder and decoded values back.
`timescale 1ns/1ps
interface brake_cfg_if;
  import brake_cfg_pkg::*;
  logic [CODE_W-1:0]    lin_code;
  logic [CODE_W-1:0]    quad_code;
  logic [BRAKE_I_W-1:0] cur_code;
  logic [ACC_W-1:0]     lin_acc;
  logic [ACC_W-1:0]     quad_acc;
  logic [CUR_W-1:0]     cur_ma;

  modport bank (output lin_code, quad_code, cur_code, input lin_acc, quad_acc, cur_ma);
  modport dec  (input lin_code, quad_code, cur_code, output lin_acc, quad_acc, cur_ma);
endinterface

// ===== rtl/brake_cfg_decode.sv
// Decoder turning coded acceleration and current fields into physical values.
`timescale 1ns/1ps
module brake_cfg_decode (
  input  wire logic ref_clk,
  input  wire logic rstn,
  brake_cfg_if.dec  cfg
);
  import brake_cfg_pkg::*;

  // ****************************************************************
  // Stepped acceleration table in 0.01 Hz/s units.
  // ****************************************************************
  function automatic logic [ACC_W-1:0] acc_step(input logic [CODE_W-1:0] code);
    case (code)
      4'h0:    acc_step = 20'h00001;
      4'h1:    acc_step = 20'h00005;
      4'h2:    acc_step = 20'h00064;
      4'h3:    acc_step = 20'h000FA;
      4'h4:    acc_step = 20'h001F4;
      4'h5:    acc_step = 20'h003E8;
      4'h6:    acc_step = 20'h009C4;
      4'h7:    acc_step = 20'h01388;
      4'h8:    acc_step = 20'h01D4C;
      4'h9:    acc_step = 20'h02710;
      4'hA:    acc_step = 20'h061A8;
      4'hB:    acc_step = 20'h0C350;
      4'hC:    acc_step = 20'h124F8;
      4'hD:    acc_step = 20'h186A0;
      4'hE:    acc_step = 20'h7A120;
      default: acc_step = 20'hF4240;
    endcase
  endfunction

  // ****************************************************************
  // Registered decode.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg.lin_acc <= '0;
    end else if (cfg.lin_code == 4'hF) begin
      cfg.lin_acc <= acc_step(4'hE); // RQ1
    end else begin
      cfg.lin_acc <= acc_step(cfg.lin_code); // RQ1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg.quad_acc <= '0;
    end else if (cfg.quad_code == 4'h0) begin
      cfg.quad_acc <= '0; // RQ2
    end else begin
      cfg.quad_acc <= acc_step(cfg.quad_code); // RQ2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg.cur_ma <= '0;
    end else if (cfg.cur_code == 3'h0) begin
      cfg.cur_ma <= BRAKE_I_ZERO_MA; // RQ3
    end else begin
      cfg.cur_ma <= CUR_W'(cfg.cur_code * BRAKE_I_STEP_MA); // RQ3
    end
  end

endmodule // brake_cfg_decode

// ===== rtl/reverse_drive_brake_config.sv
// Reverse drive and active braking configuration bank with decoded outputs and ramp.
`timescale 1ns/1ps
// How it works
// RQ1: Linear accel code decodes 0.01 to 5000 Hz/s.
// RQ2: Quadratic accel code decodes 0 to 10000.
// RQ3: Brake current limit 0.5 A, then 1-7 A.
// RQ4: Proportional gain is value over 2^7.
// RQ5: Integral gain is value over 2^9.
// RQ6: Startup word at 84h, resets zero, parity 31.
// RQ7: Reverse word at 82h, resets zero, parity 31.
// RQ8: Ramp uses linear and quadratic acceleration terms.
module reverse_drive_brake_config #(
  parameter int RAMP_TICK = brake_cfg_pkg::RAMP_TICK_CYCLES
) (
  input  wire logic                                    ref_clk,
  input  wire logic                                    rstn,
  input  wire logic [brake_cfg_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  input  wire logic [brake_cfg_pkg::DATA_W-1:0]        reg_wdata,
  output logic      [brake_cfg_pkg::DATA_W-1:0]        reg_rdata,
  input  wire logic                                    reverse_request,
  output logic      [brake_cfg_pkg::ACC_W-1:0]         reverse_linear_accel,
  output logic      [brake_cfg_pkg::ACC_W-1:0]         reverse_quadratic_accel,
  output logic      [brake_cfg_pkg::CUR_W-1:0]         brake_current_limit_ma,
  output logic      [brake_cfg_pkg::GAIN_W-1:0]        brake_prop_gain_q7,
  output logic      [brake_cfg_pkg::GAIN_W-1:0]        brake_integral_gain_q9,
  output logic                                         brake_enable,
  output logic                                         reverse_ramp_active,
  output logic      [brake_cfg_pkg::FREQ_W-1:0]        reverse_ramp_freq
);
  import brake_cfg_pkg::*;

  logic [DATA_W-1:0] reverse_drive_config;
  logic [DATA_W-1:0] motor_startup_config_one;
  ramp_state_t       ramp_state;
  ramp_state_t       next_ramp_state;
  logic [31:0]       tick_cnt;
  logic              tick;
  logic [FREQ_W-1:0] ramp_slope;
  logic              rev_sel;
  logic              startup_sel;
  logic [GAIN_W-1:0] prop_field;
  logic [GAIN_W-1:0] integral_field;
  logic              brake_en_field;
  logic              reverse_en_field;

  brake_cfg_if cfg ();

  // ****************************************************************
  // Offset match, used by the write path; the read path decodes reg_addr in its own case.
  // ****************************************************************
  function automatic logic offset_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
    offset_hit = (addr == ofs);
  endfunction

  assign rev_sel     = offset_hit(reg_addr, REV_DRIVE_OFS); // RQ7
  assign startup_sel = offset_hit(reg_addr, STARTUP_ONE_OFS); // RQ6

  // ****************************************************************
  // Reverse drive word; the parity bit is stored and read back only.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reverse_drive_config <= REV_DRIVE_RST; // RQ7
    end else if (reg_wr && rev_sel) begin
      reverse_drive_config <= reg_wdata; // RQ7
    end
  end

  // ****************************************************************
  // Startup word; every bit is writable.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      motor_startup_config_one <= STARTUP_ONE_RST; // RQ6
    end else if (reg_wr && startup_sel) begin
      motor_startup_config_one <= reg_wdata; // RQ6
    end
  end

  // ****************************************************************
  // Register reads; unmapped offsets read zero.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REV_DRIVE_OFS:   reg_rdata <= reverse_drive_config; // RQ7
        STARTUP_ONE_OFS: reg_rdata <= motor_startup_config_one; // RQ6
        default:         reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Field decode.
  // ****************************************************************
  assign cfg.lin_code  = reverse_drive_config[LIN_ACC_LSB +: CODE_W];
  assign cfg.quad_code = reverse_drive_config[QUAD_ACC_LSB +: CODE_W];
  assign cfg.cur_code  = reverse_drive_config[BRAKE_I_LSB +: BRAKE_I_W];
  assign prop_field       = reverse_drive_config[KP_LSB +: GAIN_W];
  assign integral_field   = reverse_drive_config[KI_LSB +: GAIN_W];
  assign brake_en_field   = motor_startup_config_one[BRAKE_EN_BIT];
  assign reverse_en_field = motor_startup_config_one[REV_EN_BIT];

  brake_cfg_decode u_decode (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .cfg     (cfg.dec)
  );

  // ****************************************************************
  // Decoded values driven out from the decoder flops.
  // ****************************************************************
  assign reverse_linear_accel    = cfg.lin_acc;
  assign reverse_quadratic_accel = cfg.quad_acc;
  assign brake_current_limit_ma  = cfg.cur_ma;

  // ****************************************************************
  // Braking gains, unsigned with seven and nine fraction bits.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      brake_prop_gain_q7 <= '0;
    end else begin
      brake_prop_gain_q7 <= prop_field; // RQ4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      brake_integral_gain_q9 <= '0;
    end else begin
      brake_integral_gain_q9 <= integral_field; // RQ5
    end
  end

  // ****************************************************************
  // Braking enable from the startup word.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      brake_enable <= 1'b0;
    end else begin
      brake_enable <= brake_en_field;
    end
  end

  // ****************************************************************
  // Reverse ramp tick.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn || ramp_state == RAMP_IDLE || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  assign tick = (tick_cnt == 32'(RAMP_TICK - 1));

  // ****************************************************************
  // Reverse ramp state.
  // ****************************************************************
  always_comb begin
    case (ramp_state)
      RAMP_IDLE: begin
        if (reverse_request && reverse_en_field) begin
          next_ramp_state = RAMP_RUN;
        end else begin
          next_ramp_state = RAMP_IDLE;
        end
      end
      RAMP_RUN: begin
        if (!reverse_request) begin
          next_ramp_state = RAMP_IDLE;
        end else begin
          next_ramp_state = RAMP_RUN;
        end
      end
      default: next_ramp_state = RAMP_IDLE;
    endcase
  end

  // ****************************************************************
  // Reverse ramp state register.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ramp_state <= RAMP_IDLE;
    end else begin
      ramp_state <= next_ramp_state;
    end
  end

  // ****************************************************************
  // Ramp activity seen outside.
  // ****************************************************************
  assign reverse_ramp_active = (ramp_state == RAMP_RUN);

  // ****************************************************************
  // Ramp slope grows by the quadratic term at every tick.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn || ramp_state == RAMP_IDLE) begin
      ramp_slope <= '0;
    end else if (tick) begin
      ramp_slope <= ramp_slope + FREQ_W'(cfg.quad_acc); // RQ8
    end
  end

  // ****************************************************************
  // Ramp frequency grows by the linear term plus the old slope.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn || ramp_state == RAMP_IDLE) begin
      reverse_ramp_freq <= '0;
    end else if (tick) begin
      reverse_ramp_freq <= reverse_ramp_freq + FREQ_W'(cfg.lin_acc) + ramp_slope; // RQ8
    end
  end

endmodule // reverse_drive_brake_config

// ===== sim/brake_expect_pkg.sv
// Expected decodes of the coded reverse drive and braking fields.
package brake_expect_pkg;
  function automatic logic [19:0] acc_of(input logic [3:0] c, input logic q);
    logic [19:0] t [16];
    t = '{20'h00001, 20'h00005, 20'h00064, 20'h000FA, 20'h001F4, 20'h003E8, 20'h009C4, 20'h01388,
          20'h01D4C, 20'h02710, 20'h061A8, 20'h0C350, 20'h124F8, 20'h186A0, 20'h7A120, 20'hF4240};
    if (q && c == 4'h0) return 20'h00000;
    if (!q && c == 4'hF) return 20'h7A120;
    return t[c];
  endfunction
  function automatic logic [12:0] cur_of(input logic [2:0] c);
    return (c == 3'h0) ? 13'h01F4 : 13'(c) * 13'h03E8;
  endfunction
endpackage

// ===== sim/reverse_drive_brake_config_assertions.sv
// Checker bound to the reverse drive and braking configuration bank.
`timescale 1ns/1ps
module reverse_drive_brake_config_assertions
  import brake_expect_pkg::*;
#(parameter int RAMP_TICK = 4) (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reverse_request,
  input wire logic [19:0] reverse_linear_accel,
  input wire logic [19:0] reverse_quadratic_accel,
  input wire logic [12:0] brake_current_limit_ma,
  input wire logic [9:0]  brake_prop_gain_q7,
  input wire logic [9:0]  brake_integral_gain_q9,
  input wire logic        brake_enable,
  input wire logic        reverse_ramp_active,
  input wire logic [31:0] reverse_ramp_freq
);
  logic [31:0] s82, s84, rv;
  logic [1:0]  age;
  logic [31:0] run_cnt;
  assign rv = (reg_addr == 8'h82) ? s82 : (reg_addr == 8'h84) ? s84 : 32'h00000000;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s82 <= 32'h00000000;
      s84 <= 32'h00000000;
      age <= 2'h0;
      run_cnt <= 32'h00000000;
    end else begin
      run_cnt <= reverse_ramp_active ? run_cnt + 32'h00000001 : 32'h00000000;
      if (reg_wr && reg_addr == 8'h82) s82 <= reg_wdata;
      if (reg_wr && reg_addr == 8'h84) s84 <= reg_wdata;
      age <= reg_wr ? 2'h0 : (age == 2'h3) ? age : age + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_drop;
    reverse_ramp_active && !reverse_request;
  endsequence
  a_read_word: assert property (reg_rd |=> reg_rdata == $past(rv))
    else $error("read data wrong");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_accel_decode: assert property (age == 2'h3 |-> reverse_linear_accel ==
    acc_of(s82[30:27], 1'b0) && reverse_quadratic_accel == acc_of(s82[26:23], 1'b1))
    else $error("accel decode wrong");
  a_current_decode: assert property (age == 2'h3 |-> brake_current_limit_ma ==
    cur_of(s82[22:20])) else $error("current decode wrong");
  a_gain_fields: assert property (age == 2'h3 |-> brake_prop_gain_q7 == s82[19:10] &&
    brake_integral_gain_q9 == s82[9:0] && brake_enable == s84[1]) else $error("gain wrong");
  a_ramp_start: assert property (reverse_request && s84[0] && !reverse_ramp_active |=>
    reverse_ramp_active) else $error("ramp did not start");
  a_ramp_refused: assert property (!s84[0] && !reverse_ramp_active |=> !reverse_ramp_active)
    else $error("ramp started while disabled");
  a_ramp_stop: assert property (s_drop |=> !reverse_ramp_active ##[0:1] reverse_ramp_freq == 0)
    else $error("ramp did not stop");
  a_ramp_wait: assert property (reverse_ramp_active && run_cnt < RAMP_TICK |->
    reverse_ramp_freq == 0) else $error("ramp stepped before first tick");
endmodule // reverse_drive_brake_config_assertions
bind reverse_drive_brake_config reverse_drive_brake_config_assertions #(.RAMP_TICK(RAMP_TICK)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reverse_request(reverse_request),
  .reverse_linear_accel(reverse_linear_accel), .reverse_quadratic_accel(reverse_quadratic_accel),
  .brake_current_limit_ma(brake_current_limit_ma), .brake_prop_gain_q7(brake_prop_gain_q7),
  .brake_integral_gain_q9(brake_integral_gain_q9), .brake_enable(brake_enable),
  .reverse_ramp_active(reverse_ramp_active), .reverse_ramp_freq(reverse_ramp_freq));

// ===== sim/testbench.sv
// Self-checking testbench for the reverse drive and braking configuration bank.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0]  code;
    logic [19:0] lin;
    logic [19:0] quad;
    logic [12:0] cur;
  } row_t;
  row_t rows [16] = '{
    '{4'h0, 20'h00001, 20'h00000, 13'h01F4},
    '{4'h1, 20'h00005, 20'h00005, 13'h03E8},
    '{4'h2, 20'h00064, 20'h00064, 13'h07D0},
    '{4'h3, 20'h000FA, 20'h000FA, 13'h0BB8},
    '{4'h4, 20'h001F4, 20'h001F4, 13'h0FA0},
    '{4'h5, 20'h003E8, 20'h003E8, 13'h1388},
    '{4'h6, 20'h009C4, 20'h009C4, 13'h1770},
    '{4'h7, 20'h01388, 20'h01388, 13'h1B58},
    '{4'h8, 20'h01D4C, 20'h01D4C, 13'h01F4},
    '{4'h9, 20'h02710, 20'h02710, 13'h03E8},
    '{4'hA, 20'h061A8, 20'h061A8, 13'h07D0},
    '{4'hB, 20'h0C350, 20'h0C350, 13'h0BB8},
    '{4'hC, 20'h124F8, 20'h124F8, 13'h0FA0},
    '{4'hD, 20'h186A0, 20'h186A0, 13'h1388},
    '{4'hE, 20'h7A120, 20'h7A120, 13'h1770},
    '{4'hF, 20'h7A120, 20'hF4240, 13'h1B58}
  };
  logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reverse_request = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata, freq, d;
  logic [19:0] lin, quad;
  logic [12:0] cur;
  logic [9:0]  kp, ki;
  logic        brake_enable, active;
  int          n_errors = 0, compares = 0, cycles = 0;
  always #10 ref_clk = ~ref_clk;
  reverse_drive_brake_config #(.RAMP_TICK(4)) u_reverse_drive_brake_config (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reverse_request(reverse_request),
    .reverse_linear_accel(lin), .reverse_quadratic_accel(quad), .brake_current_limit_ma(cur),
    .brake_prop_gain_q7(kp), .brake_integral_gain_q9(ki), .brake_enable(brake_enable),
    .reverse_ramp_active(active), .reverse_ramp_freq(freq));
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(e, reg_rdata, n);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic next_freq(input logic [31:0] e);
    logic [31:0] old;
    old = freq;
    for (int i = 0; i < 20 && freq === old; i++) @(posedge ref_clk);
    #1 chk(e, freq, "ramp freq");
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h82, 32'h00000000, "reverse reset");
    rd(8'h84, 32'h00000000, "startup reset");
    chk(32'h000001F4, cur, "current reset");
    foreach (rows[i]) begin
      d = {rows[i].code[0], rows[i].code, rows[i].code, rows[i].code[2:0], 10'(i * 67),
           10'(1023 - i * 61)};
      wr(8'h82, d);
      idle(3);
      chk(rows[i].lin, lin, "linear accel");
      chk(rows[i].quad, quad, "quad accel");
      chk(rows[i].cur, cur, "current");
      chk(d[19:10], kp, "prop gain");
      chk(d[9:0], ki, "integral gain");
      rd(8'h82, d, "reverse word");
    end
    wr(8'h84, 32'h80000003);
    wr(8'h86, 32'hFFFFFFFF);
    wr(8'h82, 32'h19000000);
    idle(3);
    chk(32'h00000001, brake_enable, "brake enable");
    rd(8'h84, 32'h80000003, "startup word");
    rd(8'h86, 32'h00000000, "unmapped");
    @(posedge ref_clk);
    reverse_request <= 1'b1;
    next_freq(32'h000000FA);
    chk(32'h00000001, active, "ramp active");
    next_freq(32'h00000258);
    next_freq(32'h0000041A);
    @(posedge ref_clk);
    reverse_request <= 1'b0;
    idle(3);
    chk(32'h00000000, active, "ramp stop active");
    chk(32'h00000000, freq, "ramp stop freq");
    wr(8'h84, 32'h00000000);
    @(posedge ref_clk);
    reverse_request <= 1'b1;
    idle(8);
    chk(32'h00000000, active, "ramp refused");
    @(posedge ref_clk);
    reverse_request <= 1'b0;
    rstn <= 1'b0;
    idle(2);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h82, 32'h00000000, "reverse reset");
    tally_and_finish;
  end
endmodule // testbench
